/* File: hdl/flash_cfg.svh */
// Opcodes, field positions and timing figures of the program/erase sequencer
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH

`define OP_ARM      8'h06
`define OP_STAT     8'h05
`define OP_PROG     8'h02
`define OP_QPROG    8'h32
`define OP_SCLR     8'h20
`define OP_HCLR     8'h52

`define IDX_ADDR0   3'h1
`define IDX_DATA    3'h4
`define IDX_MORE    3'h5
`define PAGE_LEN    9'h100
`define PAGE_LAST   9'h0FF

`define SMALL_MASK  24'hFF_F000
`define HALF_MASK   24'hFF_8000
`define ADDR_ONES   24'hFF_FFFF
`define BP_FINE     5'h0C
`define BP_COARSE   5'h10

`define ST_BUSY     0
`define ST_WEL      1

`define CLK_NS      25
`define NS_PER_US   1000

`endif

/* File: hdl/flash_pkg.sv */
// Types shared by the program/erase sequencer
package flash_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE} seq_st_t;
  typedef enum logic {CLR_SMALL, CLR_HALF} clr_kind_t;
endpackage

/* File: hdl/flash_prog_erase.sv */
// Serial flash program and erase command sequencer
//
// Function
// [R1] Program or erase runs only when the write latch was armed beforehand.
// [R2] Program frame: select low, opcode, three address bytes, data bytes, deselect.
// [R3] Data running past page end wraps to the page start.
// [R4] More than 256 data bytes: only the last 256 are programmed.
// [R5] Fewer bytes: only addressed bytes change, rest of page untouched.
// [R6] Select stays low through the whole program or erase frame.
// [R7] Program runs only if deselect follows a whole data byte.
// [R8] Valid program deselect launches a timed program cycle.
// [R9] Busy flag is one for the whole timed cycle, then zero.
// [R10] Status reads are served while a cycle runs.
// [R11] Write latch is cleared during each timed cycle.
// [R12] Program aimed at a protected page is not executed.
// [R13] Four-lane program takes address and data over four lanes.
// [R14] Host sets the quad lane enable before four-lane program.
// [R15] Small-region erase takes three address bytes; any inside address selects it.
// [R16] Erase runs only if deselect follows the last address byte exactly.
// [R17] Valid small-region erase starts a timed erase cycle.
// [R18] Small-region erase on a protected region is not executed.
// [R19] Half-block erase takes three address bytes; any inside address selects it.
// [R20] Valid half-block erase starts a timed erase cycle.
// [R21] Half-block erase on a protected block is not executed.
// [R22] While busy, further program or erase commands are ignored.
// [R23] Erase regions are aligned; low address bits are ignored.
`timescale 1ns/1ps
`include "flash_cfg.svh"

module flash_prog_erase #(
  parameter int unsigned PROGRAM_TIME_US     = 400,
  parameter int unsigned SMALL_ERASE_TIME_US = 45000,
  parameter int unsigned HALF_CLEAR_TIME_US  = 150000
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic                sclk_i,
  input  wire logic                chip_select_n_i,
  input  wire logic                serial_input_i,
  input  wire logic [3:0]          quad_lanes_i,
  input  wire logic                quad_lane_enable_i,
  input  wire logic [4:0]          block_protect_bits_i,
  output logic                     serial_output_o,
  output logic                     serial_output_oe_o,
  output logic                     busy_flag_o,
  output logic                     write_enable_latch_o,
  output logic                     arr_wr_o,
  output logic                     arr_erase_o,
  output flash_pkg::clr_kind_t     arr_kind_o,
  output logic [23:0]              arr_addr_o,
  output logic [7:0]               arr_wdata_o
);
  import flash_pkg::*;

  localparam int unsigned PROG_CYC = PROGRAM_TIME_US * `NS_PER_US / `CLK_NS;
  localparam int unsigned SCLR_CYC = SMALL_ERASE_TIME_US * `NS_PER_US / `CLK_NS;
  localparam int unsigned HCLR_CYC = HALF_CLEAR_TIME_US * `NS_PER_US / `CLK_NS;

  // ----------------------------------------------------------------
  // Link side, serial clock domain; shift state and output driver cleared by deselect
  // ----------------------------------------------------------------
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic       first_reg;
  logic       quad_reg;
  logic       rd_reg;
  logic       qe_s1_reg = 1'b0;
  logic       qe_s2_reg = 1'b0;
  logic       busy_s1_reg = 1'b0;
  logic       busy_s2_reg = 1'b0;
  logic       wel_s1_reg = 1'b0;
  logic       wel_s2_reg = 1'b0;
  logic       tog_reg = 1'b0;
  logic       frag_reg = 1'b0;
  logic [7:0] bbuf_reg [2] = '{8'h00, 8'h00};
  logic [7:0] st_sh_reg = 8'h00;
  logic       byte_done;

  assign sh_next   = quad_reg ? {sh_reg[3:0], quad_lanes_i}        // [R13]
                              : {sh_reg[6:0], serial_input_i};
  assign bit_next  = quad_reg ? bit_reg + 3'h4 : bit_reg + 3'h1;
  assign byte_done = (bit_next == 3'h0);

  always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      sh_reg    <= 8'h00;
      bit_reg   <= 3'h0;
      first_reg <= 1'b1;
      quad_reg  <= 1'b0;
      rd_reg    <= 1'b0;
    end else begin
      sh_reg  <= sh_next;
      bit_reg <= bit_next;
      if (byte_done) begin
        first_reg <= 1'b0;
        if (first_reg && sh_next == `OP_QPROG && qe_s2_reg) begin
          quad_reg <= 1'b1;                                        // [R13]
        end
        if (first_reg && sh_next == `OP_STAT) begin
          rd_reg <= 1'b1;                                          // [R10]
        end
      end
    end
  end

  // Byte hand-over: toggle plus two alternating holding slots
  always_ff @(posedge sclk_i) begin
    qe_s1_reg   <= quad_lane_enable_i;
    qe_s2_reg   <= qe_s1_reg;
    busy_s1_reg <= busy_flag_o;
    busy_s2_reg <= busy_s1_reg;
    wel_s1_reg  <= write_enable_latch_o;
    wel_s2_reg  <= wel_s1_reg;
    frag_reg    <= !byte_done;
    if (byte_done) begin
      bbuf_reg[!tog_reg] <= sh_next;
      tog_reg            <= !tog_reg;
    end
  end

  // Status byte shifted out on the falling edge, also while busy
  always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      serial_output_o    <= 1'b0;
      serial_output_oe_o <= 1'b0;
    end else begin
      serial_output_oe_o <= rd_reg;                                // [R10]
      serial_output_o    <= st_sh_reg[7];
    end
  end

  always_ff @(negedge sclk_i) begin
    if (rd_reg) begin
      st_sh_reg <= {st_sh_reg[6:0], st_sh_reg[7]};
    end else begin
      st_sh_reg <= 8'h00;
      st_sh_reg[`ST_BUSY] <= busy_s2_reg;
      st_sh_reg[`ST_WEL]  <= wel_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the system clock domain
  // ----------------------------------------------------------------
  logic [2:0] async_in;
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] filt_reg;

  assign async_in = {frag_reg, tog_reg, chip_select_n_i};

  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      s1_reg[g] <= async_in[g];
      s2_reg[g] <= s1_reg[g];
      s3_reg[g] <= s2_reg[g];
      if (srst_i) begin
        filt_reg[g] <= (g == 0) ? 1'b1 : 1'b0;
      end else if (s2_reg[g] == s3_reg[g]) begin
        filt_reg[g] <= s3_reg[g];
      end
    end
  end

  wire cs_f   = filt_reg[0];
  wire tog_f  = filt_reg[1];
  wire frag_f = filt_reg[2];

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  seq_st_t     st_reg;
  logic        cs_prev_reg;
  logic        tog_seen_reg;
  logic [1:0]  rise_d_reg;
  logic        ign_reg;
  logic [2:0]  idx_reg;
  logic [7:0]  opc_reg;
  logic [23:0] addr_reg;
  logic [7:0]  dcnt_reg;
  logic [7:0]  page_reg [256];
  logic [255:0] vld_reg;
  logic        wel_reg;
  logic [31:0] tmr_reg;
  logic [8:0]  scan_reg;

  wire       busy     = (st_reg != ST_IDLE);
  wire       cs_fall  = cs_prev_reg && !cs_f;
  wire       byte_ev  = (tog_f != tog_seen_reg) && !cs_f;
  wire [7:0] byte_w   = bbuf_reg[tog_f];
  wire       end_ev   = rise_d_reg[1];
  wire       take     = byte_ev && !ign_reg && !busy;              // [R22]
  wire [7:0] slot     = addr_reg[7:0] + dcnt_reg;                  // [R3]

  // Protection: top or bottom run of regions, coarse or fine units
  wire [4:0]  bp_lsb  = (block_protect_bits_i[4] ? `BP_FINE : `BP_COARSE)
                        + {2'b00, block_protect_bits_i[2:0]} - 5'h01;
  wire [23:0] bp_hi   = addr_reg >> bp_lsb;
  wire [23:0] bp_top  = `ADDR_ONES >> bp_lsb;
  wire        prot    = (block_protect_bits_i[2:0] != 3'h0)
                        && (block_protect_bits_i[3] ? (bp_hi == 24'h00_0000)
                                                    : (bp_hi == bp_top));

  wire is_prog  = (opc_reg == `OP_PROG)
                  || (opc_reg == `OP_QPROG && quad_lane_enable_i);
  wire is_clr   = (opc_reg == `OP_SCLR) || (opc_reg == `OP_HCLR);
  wire frame_ok = end_ev && !busy && !ign_reg;
  wire arm_ok   = frame_ok && !frag_f && opc_reg == `OP_ARM && idx_reg == `IDX_ADDR0;
  wire prog_ok  = frame_ok && is_prog && idx_reg == `IDX_MORE   // [R2]
                  && !frag_f && wel_reg && !prot;               // [R1] [R7] [R12]
  wire clr_ok   = frame_ok && is_clr && idx_reg == `IDX_DATA    // [R15] [R19]
                  && !frag_f && wel_reg && !prot;               // [R16] [R18] [R21]
  wire scan_end = (scan_reg == `PAGE_LEN);
  wire tmr_end  = (tmr_reg == 32'h0000_0000);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cs_prev_reg  <= 1'b1;
      tog_seen_reg <= 1'b0;
      rise_d_reg   <= 2'b00;
      ign_reg      <= 1'b0;
      idx_reg      <= 3'h0;
      opc_reg      <= 8'h00;
      addr_reg     <= 24'h00_0000;
      dcnt_reg     <= 8'h00;
      vld_reg      <= '0;
    end else begin
      cs_prev_reg  <= cs_f;
      tog_seen_reg <= tog_f;
      rise_d_reg   <= {rise_d_reg[0], cs_f && !cs_prev_reg};
      if (cs_fall) begin
        ign_reg  <= busy;                                          // [R22]
        idx_reg  <= 3'h0;
        dcnt_reg <= 8'h00;
        if (!busy) begin
          vld_reg <= '0;                                           // [R22]
        end
      end else if (take) begin
        if (idx_reg != `IDX_MORE) begin
          idx_reg <= idx_reg + 3'h1;
        end
        if (idx_reg == 3'h0) begin
          opc_reg <= byte_w;
        end else if (idx_reg < `IDX_DATA) begin
          addr_reg <= {addr_reg[15:0], byte_w};
        end else begin
          page_reg[slot] <= byte_w;                                // [R3] [R4]
          vld_reg[slot]  <= 1'b1;                                  // [R5]
          dcnt_reg       <= dcnt_reg + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Timed cycles and array strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg               <= ST_IDLE;
      wel_reg              <= 1'b0;
      tmr_reg              <= 32'h0000_0000;
      scan_reg             <= 9'h000;
      busy_flag_o          <= 1'b0;
      write_enable_latch_o <= 1'b0;
      arr_wr_o             <= 1'b0;
      arr_erase_o          <= 1'b0;
      arr_kind_o           <= CLR_SMALL;
      arr_addr_o           <= 24'h00_0000;
      arr_wdata_o          <= 8'h00;
    end else begin
      arr_wr_o    <= 1'b0;
      arr_erase_o <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          scan_reg <= 9'h000;
          if (arm_ok) begin
            wel_reg <= 1'b1;
          end
          if (prog_ok) begin
            st_reg  <= ST_PROG;                                    // [R8]
            tmr_reg <= PROG_CYC - 1;
            wel_reg <= 1'b0;                                       // [R11]
          end else if (clr_ok) begin
            st_reg      <= ST_ERASE;                               // [R17] [R20]
            tmr_reg     <= (opc_reg == `OP_SCLR) ? SCLR_CYC - 1 : HCLR_CYC - 1;
            wel_reg     <= 1'b0;                                   // [R11]
            arr_erase_o <= 1'b1;
            arr_kind_o  <= (opc_reg == `OP_SCLR) ? CLR_SMALL : CLR_HALF;
            arr_addr_o  <= addr_reg & ((opc_reg == `OP_SCLR) ? `SMALL_MASK
                                                             : `HALF_MASK); // [R23]
          end
        end
        ST_PROG: begin
          if (!tmr_end) begin
            tmr_reg <= tmr_reg - 32'h0000_0001;
          end
          if (!scan_end) begin
            scan_reg <= scan_reg + 9'h001;
            if (vld_reg[scan_reg[7:0]]) begin
              arr_wr_o    <= 1'b1;                                 // [R5]
              arr_addr_o  <= {addr_reg[23:8], scan_reg[7:0]};
              arr_wdata_o <= page_reg[scan_reg[7:0]];
            end
          end
          if (tmr_end && scan_end) begin
            st_reg <= ST_IDLE;
          end
        end
        ST_ERASE: begin
          if (tmr_end) begin
            st_reg <= ST_IDLE;
          end else begin
            tmr_reg <= tmr_reg - 32'h0000_0001;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
      busy_flag_o          <= (st_reg != ST_IDLE && !(tmr_end
                               && (st_reg == ST_ERASE || scan_end)))
                              || prog_ok || clr_ok;                // [R9]
      write_enable_latch_o <= (wel_reg || arm_ok) && !prog_ok && !clr_ok;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  chk_prog_launch: assert property (prog_ok |=> busy_flag_o && st_reg == ST_PROG) // [R8]
    else $error("program cycle not launched");
  chk_erase_launch: assert property (clr_ok |=> busy_flag_o && arr_erase_o) // [R17]
    else $error("erase cycle not launched");
  chk_busy_hold: assert property ($rose(busy_flag_o) |-> busy_flag_o [*8]) // [R9]
    else $error("busy flag dropped early");
  chk_wel_clear: assert property ($rose(busy_flag_o) |-> !write_enable_latch_o) // [R11]
    else $error("write latch still set in cycle");
  chk_arm_gate: assert property (end_ev && !busy && !wel_reg |=> !busy_flag_o) // [R1]
    else $error("cycle started without write latch");
  chk_frag_cancel: assert property (end_ev && !busy && frag_f |=> !busy_flag_o) // [R7]
    else $error("partial byte did not cancel");
  chk_prot_block: assert property (end_ev && !busy && prot |=> !busy_flag_o) // [R12]
    else $error("protected target was started");
  chk_page_stay: assert property (arr_wr_o |-> arr_addr_o[23:8] == addr_reg[23:8]) // [R3]
    else $error("write left the page");
  chk_erase_align: assert property (arr_erase_o && arr_kind_o == CLR_HALF
                                    |-> (arr_addr_o & ~`HALF_MASK) == 24'h00_0000) // [R23]
    else $error("half block base not aligned");
  chk_busy_ignore: assert property (busy && byte_ev |=> $stable(opc_reg)) // [R22]
    else $error("command taken while busy");

  cov_program: cover property (prog_ok ##1 busy_flag_o);
  cov_small_clr: cover property (clr_ok && opc_reg == `OP_SCLR);
  cov_half_clr: cover property (clr_ok && opc_reg == `OP_HCLR);
  cov_busy_frame: cover property (busy && cs_fall);

endmodule

/* File: sim/host_model.sv */
// Serial host controller model that frames commands into the sequencer
`timescale 1ns/1ps
module host_model (
  output logic       sclk_o,
  output logic       csn_o,
  output logic       si_o,
  output logic [3:0] lanes_o,
  input  wire logic  so_i
);
  logic [7:0] fb [0:299];

  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    si_o = 1'b1;
    lanes_o = 4'h0;
  end

  // ----------------------------------------
  // Bit timing, clock idles low between frames
  // ----------------------------------------
  task automatic tick(input logic b, input logic [3:0] q);
    si_o = b;
    lanes_o = q;
    #24 sclk_o = 1'b1;
    #24 sclk_o = 1'b0;
  endtask

  // Whole bytes, then cut stray bits that also sample the output line
  task automatic frame(input int n, input int cut, input bit qd,
                       output logic [7:0] rd);
    rd = 8'h00;
    #7 csn_o = 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      if (qd && i > 0) begin
        tick(~si_o, fb[i][7:4]);
        tick(~si_o, fb[i][3:0]);
      end else begin
        for (int k = 7; k >= 0; k--) tick(fb[i][k], ~lanes_o);
      end
    end
    for (int k = 0; k < cut; k++) begin
      si_o = ~si_o;
      #24 sclk_o = 1'b1;
      rd = {rd[6:0], so_i};
      #24 sclk_o = 1'b0;
    end
    #100 csn_o = 1'b1;
    si_o = ~si_o;
    lanes_o = ~lanes_o;
    #200;
  endtask
endmodule

/* File: sim/tb_flash_prog_erase.sv */
// Self-checking bench for the program and erase sequencer
`timescale 1ns/1ps
`include "flash_cfg.svh"
module tb_flash_prog_erase;
  import flash_pkg::*;
  logic        clk, srst, sclk, csn, si, qen, so, so_oe, busy, write_enable_latch, wr, er;
  logic [3:0]  lanes;
  logic [4:0]  bp;
  clr_kind_t   kind;
  logic [23:0] addr;
  logic [7:0]  wdata, rd;
  logic [23:0] wa[$], ea[$];
  logic [7:0]  wd[$];
  clr_kind_t   ek[$];
  int          bcnt, oe_cnt, fail_count, n_compared;

  flash_prog_erase #(.PROGRAM_TIME_US(10), .SMALL_ERASE_TIME_US(20),
    .HALF_CLEAR_TIME_US(30)) flash_prog_erase_inst (.clk_i(clk), .srst_i(srst),
    .sclk_i(sclk), .chip_select_n_i(csn), .serial_input_i(si), .quad_lanes_i(lanes),
    .quad_lane_enable_i(qen), .block_protect_bits_i(bp), .serial_output_o(so),
    .serial_output_oe_o(so_oe), .busy_flag_o(busy), .write_enable_latch_o(write_enable_latch),
    .arr_wr_o(wr), .arr_erase_o(er), .arr_kind_o(kind), .arr_addr_o(addr),
    .arr_wdata_o(wdata));
  host_model host_model_inst (.sclk_o(sclk), .csn_o(csn), .si_o(si),
    .lanes_o(lanes), .so_i(so_oe === 1'b1 ? so : ~so));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wr === 1'b1) begin
      wa.push_back(addr);
      wd.push_back(wdata);
    end
    if (er === 1'b1) begin
      ea.push_back(addr);
      ek.push_back(kind);
    end
    if (busy === 1'b1) bcnt++;
  end

  // Output enable seen at the host's sampling edges
  always @(posedge sclk) begin
    if (so_oe === 1'b1) oe_cnt++;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic go(input int n, input int cut, input bit qd);
    host_model_inst.frame(n, cut, qd, rd);
    repeat (20) @(posedge clk);
  endtask
  task automatic ld(input logic [7:0] op, input logic [23:0] a);
    host_model_inst.fb[0] = op;
    {host_model_inst.fb[1], host_model_inst.fb[2], host_model_inst.fb[3]} = a;
  endtask
  task automatic arm();
    host_model_inst.fb[0] = `OP_ARM;
    go(1, 0, 0);
  endtask
  task automatic idle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
    chk(busy, 0);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #1_000_000;
    fail_count++;
    close_out();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    qen = 1'b0;
    bp = 5'h00;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    ld(`OP_PROG, 24'h00_0100);
    host_model_inst.fb[4] = 8'hAA;
    go(5, 0, 0);
    chk(busy, 0);
    chk(wa.size(), 0);
    arm();
    chk(write_enable_latch, 1);
    ld(`OP_PROG, 24'h00_12FE);
    {host_model_inst.fb[4], host_model_inst.fb[5]} = 16'h1122;
    {host_model_inst.fb[6], host_model_inst.fb[7]} = 16'h3344;
    bcnt = 0;
    go(8, 0, 0);
    host_model_inst.fb[0] = `OP_STAT;
    go(1, 8, 0);
    chk(rd, 1);
    chk(oe_cnt, 8);
    idle();
    chk(bcnt >= 400 && bcnt <= 401, 1);
    chk(wa.size(), 4);
    chk({wa[0], wd[0]}, 32'h0012_0033);
    chk({wa[1], wd[1]}, 32'h0012_0144);
    chk({wa[2], wd[2]}, 32'h0012_FE11);
    chk({wa[3], wd[3]}, 32'h0012_FF22);
    arm();
    ld(`OP_PROG, 24'h00_0300);
    for (int i = 0; i < 258; i++) host_model_inst.fb[4+i] = i[8:1];
    wa.delete();
    wd.delete();
    go(262, 0, 0);
    idle();
    chk(wa.size(), 256);
    chk({wa[0], wd[0]}, 32'h0003_0080);
    chk({wa[1], wd[1]}, 32'h0003_0180);
    chk({wa[255], wd[255]}, 32'h0003_FF7F);
    arm();
    ld(`OP_PROG, 24'h00_0500);
    host_model_inst.fb[4] = 8'h01;
    wa.delete();
    wd.delete();
    go(5, 3, 0);
    chk(busy, 0);
    chk(write_enable_latch, 1);
    ld(`OP_SCLR, 24'h00_5000);
    go(5, 0, 0);
    chk(busy, 0);
    chk(ea.size(), 0);
    ld(`OP_QPROG, 24'h00_0600);
    host_model_inst.fb[4] = 8'hC3;
    go(5, 0, 1);
    chk(busy, 0);
    @(posedge clk) qen <= 1'b1;
    ld(`OP_QPROG, 24'h00_0600);
    host_model_inst.fb[4] = 8'hC3;
    go(5, 0, 1);
    idle();
    chk(wa.size(), 1);
    chk({wa[0], wd[0]}, 32'h0006_00C3);
    for (int k = 0; k < 2; k++) begin
      arm();
      ld(k ? `OP_HCLR : `OP_SCLR, 24'h12_ABCD);
      ea.delete();
      ek.delete();
      bcnt = 0;
      go(4, 0, 0);
      go(4, 0, 0);
      idle();
      chk(ea.size(), 1);
      chk(ea[0], k ? 24'h12_8000 : 24'h12_A000);
      chk(ek[0], k);
      chk(bcnt, k ? 1200 : 800);
    end
    @(posedge clk) bp <= 5'h01;
    for (int k = 0; k < 3; k++) begin
      arm();
      ld(k == 0 ? `OP_PROG : k == 1 ? `OP_SCLR : `OP_HCLR, 24'hFF_8100);
      host_model_inst.fb[4] = 8'h00;
      go(k == 0 ? 5 : 4, 0, 0);
      chk(busy, 0);
    end
    close_out();
  end
endmodule
